//--- core/sxc_setup.sv
// ID, arbitration priority and synchronous transfer setup registers with strobe dividers.
// Assumes a single-cycle register port, synchronous inputs and one 50 MHz clock.
//
// Notes on behaviour
// - Reselection enable answers reselection at response ID
// - Reselection never changes configured role
// - Selection enable answers selection at response ID
// - Selection never changes configured role
// - Own ID held and driven in arbitration
// - Priority order seven down to eight
// - Send period equals code plus four
// - Send strobe rate clock over divisor, period
// - Receive rate clock over divisor, four
// - Table indirect load replaces period and offset
// - Offset zero async, one to eight, rest reserved
// - Sync settings only in data phases
// - Destination ID feeds selection and reselection
// - Script instruction writes destination ID
// - Clock divisor code selects one to four
`include "sxc_cfg.svh"
module sxc_setup
(
	input  wire logic                   i_clock,
	input  wire logic                   i_rstn,
	input  wire sxc_pkg::sxc_bus_req_t  i_bus,
	output logic [7:0]                  o_rdata,
	input  wire logic                   i_tbl_load,
	input  wire logic [7:0]             i_tbl_xfer,
	input  wire logic                   i_script_dest_wr,
	input  wire logic [3:0]             i_script_dest_id,
	input  wire logic [3:0]             i_response_id,
	input  wire sxc_pkg::sxc_sel_event_t i_sel_event,
	input  wire sxc_pkg::sxc_phase_t    i_phase,
	input  wire logic                   i_role_target,
	input  wire logic [3:0]             i_arb_peer_id,
	output logic                        o_sel_respond,
	output logic                        o_resel_respond,
	output logic                        o_role_target,
	output logic [3:0]                  o_arb_id,
	output logic [3:0]                  o_dest_id,
	output logic                        o_arb_win,
	output logic                        o_sync_mode,
	output logic [3:0]                  o_sync_offset,
	output logic                        o_send_strobe,
	output logic                        o_recv_strobe
);
	import sxc_pkg::*;

	logic [7:0] xfer_q;
	logic [7:0] own_q;
	logic [3:0] dest_q;
	logic [2:0] scf_q;
	logic [3:0] send_cnt_q;
	logic [3:0] recv_cnt_q;
	logic [2:0] pre_cnt_q;
	logic       half_q;
	logic       pre_tick;
	logic [3:0] period;
	logic       data_phase;
	logic       offset_ok;
	logic       wr_xfer;

	////////////////////////////////////////////////////////////////////////
	// Priority rank: 7..0 map to 15..8, 15..8 map to 7..0
	function automatic logic [3:0] sxc_rank(input logic [3:0] id);
		sxc_rank = {~id[3], id[2:0]};
	endfunction : sxc_rank

	////////////////////////////////////////////////////////////////////////
	// Register writes
	assign wr_xfer = i_bus.wr && (i_bus.addr == `SXC_OFS_XFER);

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			xfer_q <= `SXC_XFER_RST;
		else if (i_tbl_load)
			xfer_q <= {i_tbl_xfer[7:5], 1'b0, i_tbl_xfer[3:0]};
		else if (wr_xfer)
			xfer_q <= {i_bus.wdata[7:5], 1'b0, i_bus.wdata[3:0]};
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			own_q <= `SXC_OWN_RST;
		else if (i_bus.wr && (i_bus.addr == `SXC_OFS_OWN))
			own_q <= {1'b0, i_bus.wdata[6:5], 1'b0, i_bus.wdata[3:0]};
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			dest_q <= `SXC_DEST_RST;
		else if (i_script_dest_wr)
			dest_q <= i_script_dest_id;
		else if (i_bus.wr && (i_bus.addr == `SXC_OFS_DEST))
			dest_q <= i_bus.wdata[3:0];
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			scf_q <= `SXC_CTL3_RST;
		else if (i_bus.wr && (i_bus.addr == `SXC_OFS_CTL3))
			scf_q <= i_bus.wdata[6:4];
	end

	////////////////////////////////////////////////////////////////////////
	// Read port, data one cycle after strobe
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			o_rdata <= 8'h00;
		else if (i_bus.rd)
		begin
			case (i_bus.addr)
				`SXC_OFS_XFER: o_rdata <= xfer_q;
				`SXC_OFS_DEST: o_rdata <= {4'h0, dest_q};
				`SXC_OFS_OWN:  o_rdata <= own_q;
				`SXC_OFS_CTL3: o_rdata <= {1'b0, scf_q, 4'h0};
				`SXC_OFS_STAT: o_rdata <= {5'h00, o_send_strobe, o_sync_mode, o_arb_win};
				default:       o_rdata <= 8'h00;
			endcase
		end
		else
			o_rdata <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Selection and arbitration
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_sel_respond   <= 1'b0;
			o_resel_respond <= 1'b0;
		end
		else
		begin
			o_resel_respond <= own_q[`SXC_BIT_RESEL] && i_sel_event.resel_seen
				&& (i_sel_event.bus_id == i_response_id);
			o_sel_respond   <= own_q[`SXC_BIT_SEL] && i_sel_event.sel_seen
				&& (i_sel_event.bus_id == i_response_id);
		end
	end

	// Role follows only its configuration input
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			o_role_target <= 1'b0;
		else
			o_role_target <= i_role_target;
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_arb_id  <= 4'h0;
			o_dest_id <= 4'h0;
			o_arb_win <= 1'b0;
		end
		else
		begin
			o_arb_id  <= own_q[3:0];
			o_dest_id <= dest_q;
			o_arb_win <= sxc_rank(own_q[3:0]) >= sxc_rank(i_arb_peer_id);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Offset and mode
	assign data_phase = (i_phase == SXC_PH_DATA_IN) || (i_phase == SXC_PH_DATA_OUT);
	assign offset_ok  = (xfer_q[3:0] <= `SXC_MAX_OFFSET);

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_sync_mode   <= 1'b0;
			o_sync_offset <= 4'h0;
		end
		else
		begin
			o_sync_mode   <= data_phase && offset_ok && (xfer_q[3:0] != 4'h0);
			o_sync_offset <= (data_phase && offset_ok) ? xfer_q[3:0] : 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Prescaler: divisor 1, 1.5, 2, 3, 4; 1.5 alternates 1 and 2
	always_comb
	begin
		case (scf_q)
			3'h1: pre_tick = 1'b1;
			3'h2: pre_tick = half_q ? (pre_cnt_q == 3'h1) : 1'b1;
			3'h3: pre_tick = (pre_cnt_q == 3'h1);
			3'h0, 3'h4: pre_tick = (pre_cnt_q == 3'h2);
			3'h5: pre_tick = (pre_cnt_q == 3'h3);
			default: pre_tick = 1'b0;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			pre_cnt_q <= 3'h0;
			half_q    <= 1'b0;
		end
		else if (pre_tick)
		begin
			pre_cnt_q <= 3'h0;
			half_q    <= ~half_q;
		end
		else
			pre_cnt_q <= pre_cnt_q + 3'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// Send and receive strobe dividers
	assign period = {1'b0, xfer_q[7:5]} + `SXC_PERIOD_BASE;

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			send_cnt_q    <= 4'h0;
			o_send_strobe <= 1'b0;
		end
		else if (!o_sync_mode || wr_xfer)
		begin
			send_cnt_q    <= 4'h0;
			o_send_strobe <= 1'b0;
		end
		else if (pre_tick)
		begin
			o_send_strobe <= (send_cnt_q == period - 4'h1);
			send_cnt_q    <= (send_cnt_q == period - 4'h1) ? 4'h0 : send_cnt_q + 4'h1;
		end
		else
			o_send_strobe <= 1'b0;
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			recv_cnt_q    <= 4'h0;
			o_recv_strobe <= 1'b0;
		end
		else if (!o_sync_mode)
		begin
			recv_cnt_q    <= 4'h0;
			o_recv_strobe <= 1'b0;
		end
		else if (pre_tick)
		begin
			o_recv_strobe <= (recv_cnt_q == `SXC_RECV_PERIOD - 4'h1);
			recv_cnt_q    <= (recv_cnt_q == `SXC_RECV_PERIOD - 4'h1) ? 4'h0 : recv_cnt_q + 4'h1;
		end
		else
			o_recv_strobe <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	AST_RESEL_GATE: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_resel_respond |-> $past(own_q[`SXC_BIT_RESEL]))
		else $error("reselect answered while disabled");
	AST_SEL_GATE: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_sel_respond |-> $past(own_q[`SXC_BIT_SEL]) && $past(i_sel_event.sel_seen))
		else $error("select answered while disabled");
	AST_ROLE_HOLD: assert property (@(posedge i_clock) disable iff (!i_rstn)
		$past(i_rstn) |-> o_role_target == $past(i_role_target))
		else $error("role changed on its own");
	AST_ARB_ID: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_bus.wr && i_bus.addr == `SXC_OFS_OWN) |-> ##2 o_arb_id == $past(i_bus.wdata[3:0], 2))
		else $error("arbitration id not from own id");
	AST_RANK: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(own_q[3:0] == 4'h7) |=> o_arb_win)
		else $error("id seven lost arbitration");
	AST_TBL_LOAD: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_tbl_load |=> xfer_q[3:0] == $past(i_tbl_xfer[3:0]) && xfer_q[7:5] == $past(i_tbl_xfer[7:5]))
		else $error("table load not applied");
	AST_ASYNC_PHASE: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_phase == SXC_PH_OTHER) |=> !o_sync_mode && o_sync_offset == 4'h0)
		else $error("sync outside data phase");
	AST_RESERVED_OFS: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(xfer_q[3:0] > `SXC_MAX_OFFSET) |=> !o_sync_mode)
		else $error("reserved offset used");
	AST_SEND_GAP: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(o_send_strobe && o_sync_mode && scf_q == 3'h1 && xfer_q[7:5] == 3'h0 && !wr_xfer)
		##1 (o_sync_mode && scf_q == 3'h1 && xfer_q[7:5] == 3'h0 && !wr_xfer)[*3]
		|=> o_send_strobe)
		else $error("send period not four");
	AST_RECV_GAP: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(o_recv_strobe && scf_q == 3'h1) |=> !o_recv_strobe)
		else $error("receive strobe too close");
	AST_RECV_PERIOD: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(o_recv_strobe && o_sync_mode && scf_q == 3'h1) ##1 (o_sync_mode && scf_q == 3'h1)[*3]
		|=> o_recv_strobe)
		else $error("receive period not four");
	AST_DEST_SCRIPT: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_script_dest_wr |=> dest_q == $past(i_script_dest_id))
		else $error("script destination not stored");
	AST_DEST_BUS: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_bus.wr && i_bus.addr == `SXC_OFS_DEST && !i_script_dest_wr) |=> dest_q == $past(i_bus.wdata[3:0]))
		else $error("destination write lost");
	AST_DEST_OUT: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_dest_id == $past(dest_q))
		else $error("destination id output stale");
	AST_XFER_READ: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_bus.rd && i_bus.addr == `SXC_OFS_XFER) |=> o_rdata == $past(xfer_q))
		else $error("transfer setup read wrong");
	AST_OWN_RSVD: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_bus.rd && i_bus.addr == `SXC_OFS_OWN) |=> !o_rdata[7] && !o_rdata[4])
		else $error("reserved own id bits set");
	AST_CTL3_WRITE: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_bus.wr && i_bus.addr == `SXC_OFS_CTL3) |=> scf_q == $past(i_bus.wdata[6:4]))
		else $error("clock divisor write lost");
	AST_PRESCALE_FOUR: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(pre_tick && scf_q == 3'h5) ##1 (scf_q == 3'h5)[*4] |-> pre_tick)
		else $error("divide by four tick missing");
	AST_RANK_LOW: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(own_q[3:0] == 4'h8 && i_arb_peer_id != 4'h8) |=> !o_arb_win)
		else $error("id eight won arbitration");
	AST_SYNC_OFFSET: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(data_phase && xfer_q[3:0] <= `SXC_MAX_OFFSET) |=> o_sync_offset == $past(xfer_q[3:0]))
		else $error("sync offset not applied");
	AST_SEND_OFF: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!o_sync_mode |=> !o_send_strobe)
		else $error("send strobe outside sync mode");
	AST_RECV_OFF: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!o_sync_mode |=> !o_recv_strobe)
		else $error("receive strobe outside sync mode");
	AST_SEL_ROLE: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_sel_event.sel_seen && !i_role_target) |=> !o_role_target)
		else $error("selection switched role");
	AST_RESEL_ROLE: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_sel_event.resel_seen && i_role_target) |=> o_role_target)
		else $error("reselection switched role");
	AST_RESEL_OTHER: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_sel_event.resel_seen && i_sel_event.bus_id != i_response_id) |=> !o_resel_respond)
		else $error("reselect answered at other id");
	AST_SEL_OTHER: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_sel_event.sel_seen && i_sel_event.bus_id != i_response_id) |=> !o_sel_respond)
		else $error("select answered at other id");
endmodule : sxc_setup

//--- core/sxc_cfg.svh
// Offsets, field positions, reset values and timing counts of the ID and transfer setup bank.
// Assumes a plain byte-wide register port and one 50 MHz clock.
`ifndef SXC_CFG_SVH
`define SXC_CFG_SVH
`define SXC_OFS_XFER       8'h05
`define SXC_OFS_DEST       8'h06
`define SXC_OFS_OWN        8'h04
`define SXC_OFS_CTL3       8'h03
`define SXC_OFS_STAT       8'h08
`define SXC_XFER_RST       8'h00
`define SXC_OWN_RST        8'h00
`define SXC_DEST_RST       4'h0
`define SXC_CTL3_RST       3'h0
`define SXC_BIT_RESEL      6
`define SXC_BIT_SEL        5
`define SXC_PERIOD_BASE    4'h4
`define SXC_RECV_PERIOD    4'h4
`define SXC_MAX_OFFSET     4'h8
`endif

//--- core/sxc_pkg.sv
// Types shared by the ID and transfer setup bank.
// Assumes sxc_cfg.svh is on the include path.
package sxc_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sxc_bus_req_t;

	typedef struct packed {
		logic       sel_seen;
		logic       resel_seen;
		logic [3:0] bus_id;
	} sxc_sel_event_t;

	typedef enum logic [1:0] {
		SXC_PH_DATA_OUT,
		SXC_PH_DATA_IN,
		SXC_PH_OTHER
	} sxc_phase_t;

	typedef enum logic {
		SXC_ROLE_INITIATOR,
		SXC_ROLE_TARGET
	} sxc_role_t;
endpackage : sxc_pkg

//--- test/sxc_scsi_peer.sv
// Far-side SCSI device: selects, reselects and contends in arbitration.
// Assumes bench commands change just after a rising clock edge.
module sxc_scsi_peer
(
	input  wire logic              i_clock,
	input  wire logic              i_sel,
	input  wire logic              i_resel,
	input  wire logic [3:0]        i_id,
	input  wire logic [3:0]        i_arb,
	output sxc_pkg::sxc_sel_event_t o_event  = '0,
	output logic [3:0]             o_arb_id = 4'h0
);
	import sxc_pkg::*;
	always @(posedge i_clock)
	begin
		o_arb_id           <= i_arb;
		o_event.sel_seen   <= i_sel;
		o_event.resel_seen <= i_resel;
		// Released id lines show the inverse of the last value
		o_event.bus_id     <= (i_sel | i_resel) ? i_id : ~o_event.bus_id;
	end
endmodule : sxc_scsi_peer

//--- test/testbench.sv
// Self-checking bench for the ID and transfer setup bank.
// Assumes the setup bank and the SCSI peer model are compiled first.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import sxc_pkg::*;
	typedef struct {logic [3:0] own, peer; logic win; logic [7:0] ctl, xfer; int sg, rg;} sxc_tb_row_t;
	logic         i_clock = 1'b0;
	logic         i_rstn  = 1'b0;
	sxc_bus_req_t i_bus   = '0;
	logic         tbl_ld  = 1'b0, sdw = 1'b0, role = 1'b0, p_sel = 1'b0, p_resel = 1'b0;
	logic [7:0]   tbl_x   = 8'h00, v, rdata;
	logic [3:0]   destination_bus_id    = 4'h0, resp = 4'h5, p_id = 4'h0, p_arb = 4'h0, peer_id, arb_id, dest_id, offs;
	sxc_sel_event_t ev;
	sxc_phase_t   phase   = SXC_PH_DATA_OUT;
	logic         sel_r, resel_r, role_q, win, smode, s_stb, r_stb;
	int           err_count = 0, checked = 0, sg, rg;
	logic [7:0]   ofs [5] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h10};
	sxc_tb_row_t  rows [5] = '{
		'{4'h7, 4'h0, 1'b1, 8'h10, 8'h01, 4, 4},
		'{4'h0, 4'hF, 1'b1, 8'h30, 8'hE8, 22, 8},
		'{4'hF, 4'h0, 1'b0, 8'h50, 8'h24, 20, 16},
		'{4'h8, 4'h9, 1'b0, 8'h00, 8'h63, 21, 12},
		'{4'h3, 4'h3, 1'b1, 8'h20, 8'h02, 6, 6}};

	always #10 i_clock = ~i_clock;

	sxc_scsi_peer i_peer (.i_clock(i_clock), .i_sel(p_sel), .i_resel(p_resel), .i_id(p_id), .i_arb(p_arb),
		.o_event(ev), .o_arb_id(peer_id));
	sxc_setup i_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_bus(i_bus), .o_rdata(rdata), .i_tbl_load(tbl_ld),
		.i_tbl_xfer(tbl_x), .i_script_dest_wr(sdw), .i_script_dest_id(destination_bus_id), .i_response_id(resp),
		.i_sel_event(ev), .i_phase(phase), .i_role_target(role), .i_arb_peer_id(peer_id),
		.o_sel_respond(sel_r), .o_resel_respond(resel_r), .o_role_target(role_q), .o_arb_id(arb_id),
		.o_dest_id(dest_id), .o_arb_win(win), .o_sync_mode(smode), .o_sync_offset(offs),
		.o_send_strobe(s_stb), .o_recv_strobe(r_stb));

	////////////////////////////////////////////////////////////////
	task check(input string n, input logic [31:0] s, e);
		checked++;
		if (s !== e)
		begin
			err_count++;
			$display("MISMATCH %s expected %0h seen %0h", n, e, s);
		end
	endtask : check

	task wr(input logic [7:0] a, d);
		@(posedge i_clock);
		i_bus <= {a, d, 2'b10};
		@(posedge i_clock);
		i_bus <= '0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clock);
		i_bus <= {a, 8'h00, 2'b01};
		@(posedge i_clock);
		i_bus <= '0;
		@(negedge i_clock);
		d = rdata;
	endtask : rd

	// Gap between the second and third strobe of each kind
	task automatic gaps(output int s, output int r);
		int ts[$], tr[$];
		for (int k = 0; k < 300; k++)
		begin
			@(negedge i_clock);
			if (s_stb === 1'b1) ts.push_back(k);
			if (r_stb === 1'b1) tr.push_back(k);
		end
		s = (ts.size() > 2) ? ts[2] - ts[1] : -1;
		r = (tr.size() > 2) ? tr[2] - tr[1] : -1;
	endtask : gaps

	task end_of_test;
		$display("Comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (10) @(posedge i_clock);
		i_rstn <= 1'b1;
		foreach (ofs[k])
		begin
			rd(ofs[k], v);
			check("reset read", v, 8'h00);
		end
		// Divisor codes /1, /2, /4, /3, /1.5; send periods four, eleven, five, seven and four
		foreach (rows[k])
		begin
			wr(8'h03, rows[k].ctl);
			wr(8'h04, {4'h0, rows[k].own});
			wr(8'h05, rows[k].xfer);
			p_arb <= rows[k].peer;
			repeat (4) @(negedge i_clock);
			check("arb id", arb_id, rows[k].own);
			check("arb win", win, rows[k].win);
			check("sync mode", smode, 1'b1);
			check("sync offset", offs, rows[k].xfer[3:0]);
			gaps(sg, rg);
			check("send gap", sg, rows[k].sg);
			check("recv gap", rg, rows[k].rg);
			rd(8'h05, v);
			check("xfer read", v, rows[k].xfer);
		end
		wr(8'h06, 8'hFF);
		rd(8'h06, v);
		check("dest reserved", v, 8'h0F);
		check("dest id", dest_id, 4'hF);
		wr(8'h04, 8'hFF);
		rd(8'h04, v);
		check("own reserved", v, 8'h6F);
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h04, {1'b0, i[1], i[0], 5'h02});
			role <= i[0];
			p_sel <= 1'b1;
			p_resel <= 1'b1;
			p_id <= resp;
			repeat (4) @(negedge i_clock);
			check("sel respond", sel_r, i[0]);
			check("resel respond", resel_r, i[1]);
			check("role", role_q, i[0]);
			@(posedge i_clock);
			p_id <= 4'h6;
			repeat (4) @(negedge i_clock);
			check("other id", {sel_r, resel_r}, 2'b00);
		end
		@(posedge i_clock);
		p_sel <= 1'b0;
		p_resel <= 1'b0;
		wr(8'h05, 8'h01);
		phase <= SXC_PH_OTHER;
		repeat (3) @(negedge i_clock);
		check("other phase", {smode, offs}, 5'h00);
		rd(8'h08, v);
		check("status", v, 8'h00);
		@(posedge i_clock);
		phase <= SXC_PH_DATA_IN;
		repeat (3) @(negedge i_clock);
		check("data in", {smode, offs}, 5'h11);
		wr(8'h05, 8'h09);
		repeat (3) @(negedge i_clock);
		check("reserved offset", {smode, offs}, 5'h00);
		@(posedge i_clock);
		i_bus <= {8'h05, 8'h00, 2'b10};
		tbl_ld <= 1'b1;
		tbl_x <= 8'hFF;
		@(posedge i_clock);
		i_bus <= '0;
		tbl_ld <= 1'b0;
		rd(8'h05, v);
		check("table load", v, 8'hEF);
		@(posedge i_clock);
		i_bus <= {8'h06, 8'h03, 2'b10};
		sdw <= 1'b1;
		destination_bus_id <= 4'hA;
		@(posedge i_clock);
		i_bus <= '0;
		sdw <= 1'b0;
		rd(8'h06, v);
		check("script dest", v, 8'h0A);
		check("script dest id", dest_id, 4'hA);
		@(posedge i_clock);
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_rstn <= 1'b1;
		rd(8'h05, v);
		check("second reset", {v, smode}, 9'h000);
		end_of_test();
	end
endmodule : testbench
